// [design/tdf_data_filter.v]
// tdc conversion acceptance filter with apb register access
`default_nettype none
`include "tdf_defs.vh"

// Overview of operation
// - 32 channel inputs, or 16 in reduced variant, plus one shared timing input.
// - channels muxed by four into two 12-bit converters, sixteen channels each.
// - conversion takes 6.4 us (32 ch) or 3.2 us (16 ch), always.
// - config bit 10 selects common-start or common-stop mode.
// - sliding scale adds offset before conversion, subtracts it after.
// - with sliding scale, codes above 3840 are flagged as overflowed.
// - value passes when at or above its channel limit at 0x080-0x0BF.
// - below-limit value dropped unless bit 4 set; then stored with bit 13.
// - granularity 0: compare 8 msbs, below when value < limit*16.
// - granularity 1: below when bits 1-8 < limit and bits 9-11 zero.
// - per-channel discard bit blocks storing that channel.
// - limit memory survives every reset.
// - overflowed values not stored by default.
// - keep-overflow stores overflowed values too, marking them with bit 12.
// - common-stop saturated channel self-resets, ready about 700 ns later.
// - stop during self-reset gives invalid datum flagged by bit 14.
// - invalid data dropped unless keep-invalid bit set.
// - control logic drives timing signal, and discharge after digitising.
// - limits are undefined until software writes them.
// - accepted values leave as consecutive 32-bit words.
module tdf_data_filter #(
  parameter NCH = 32,
  parameter CH_PER_ADC = 16,
  parameter MUX_GROUP = 4
) (
  input  wire                   clk,
  input  wire                   rstn,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [11:0]            paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  input  wire [NCH-1:0]         chanStopIn,
  input  wire                   sharedTimingInput,
  input  wire [11:0]            adcCodeA,
  input  wire [11:0]            adcCodeB,
  input  wire                   adcOvfA,
  input  wire                   adcOvfB,
  input  wire [NCH-1:0]         chanSaturated,
  output reg  [1:0]             adcGroupSel,
  output reg  [1:0]             adcChanSel,
  output reg  [11:0]            slideOffset,
  output reg                    timingDrive,
  output reg                    dischargeDrive,
  output reg  [31:0]            wordOut,
  output reg                    wordValid
);
  localparam CONV_NS = (NCH == 32) ? `TDF_CONV32_NS : `TDF_CONV16_NS;
  localparam CONV_CYC = (CONV_NS * (`TDF_CLK_HZ / 1000000) + 999) / 1000;
  localparam SLICE_CYC = CONV_CYC / CH_PER_ADC;
  localparam SR_CYC = (`TDF_SELFRST_NS * (`TDF_CLK_HZ / 1000000)) / 1000;
  localparam ST_IDLE = 3'd0, ST_CONV = 3'd1, ST_DISCH = 3'd2, ST_DONE = 3'd3;
  localparam [15:0] DISCH_CYC = `TDF_DISCH_CYC;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg  [NCH-1:0] stopS1_q, stopS2_q, satS1_q, satS2_q;
  reg            timS1_q, timS2_q, timPrev_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stopS1_q  <= {NCH{1'b0}};
      stopS2_q  <= {NCH{1'b0}};
      satS1_q   <= {NCH{1'b0}};
      satS2_q   <= {NCH{1'b0}};
      timS1_q   <= 1'b0;
      timS2_q   <= 1'b0;
      timPrev_q <= 1'b0;
    end else begin
      stopS1_q  <= chanStopIn;
      stopS2_q  <= stopS1_q;
      satS1_q   <= chanSaturated;
      satS2_q   <= satS1_q;
      timS1_q   <= sharedTimingInput;
      timS2_q   <= timS1_q;
      timPrev_q <= timS2_q;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [15:0] cfg_q;
  reg  [11:0] slide_q;
  reg  [8:0]  limMem [0:NCH-1];
  // written flags share the limit memory's life: power-up value only
  reg  [NCH-1:0] limSet_q = {NCH{1'b0}};
  reg  [15:0] evCount_q;
  reg         startReq_q;
  wire        wrEn = psel & penable & pwrite & pready;
  wire        rdPh = psel & ~penable;
  wire        isLim = (paddr >= `TDF_OFF_LIM_LO) && (paddr <= `TDF_OFF_LIM_HI);
  wire [4:0]  limIdx = paddr[5:1];
  wire        stopMode = cfg_q[`TDF_CFG_STOPMODE];

  // limit memory has no reset, contents only defined after a write
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gLim
      always @(posedge clk) begin
        if (wrEn && isLim && limIdx == g) begin
          limMem[g] <= pwdata[8:0];
        end
      end
    end
  endgenerate

  always @(posedge clk) begin
    if (wrEn && isLim) begin
      limSet_q[limIdx] <= 1'b1;
    end
  end

  // ----------------------------------------
  // conversion sequencer
  // ----------------------------------------
  reg  [2:0]  state_q;
  reg  [15:0] cyc_q;
  reg  [4:0]  slot_q;
  reg  [NCH-1:0] armed_q, stopSeen_q, invalid_q;
  reg  [9:0]  srCnt_q [0:NCH-1];
  reg  [11:0] codeA_q, codeB_q;
  reg         ovfA_q, ovfB_q;
  // any accepted start, pin edge or register strobe
  wire        startNow = (state_q == ST_IDLE) && ((timS2_q && !timPrev_q) || startReq_q);

  // per-channel self-reset after saturation in common-stop mode
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gSr
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          srCnt_q[g]    <= 10'h000;
          invalid_q[g]  <= 1'b0;
          stopSeen_q[g] <= 1'b0;
        end else if (startNow) begin
          invalid_q[g]  <= 1'b0;
          stopSeen_q[g] <= 1'b0;
        end else begin
          if (stopMode && satS2_q[g] && srCnt_q[g] == 10'h000) begin
            srCnt_q[g] <= SR_CYC[9:0];
          end else if (srCnt_q[g] != 10'h000) begin
            srCnt_q[g] <= srCnt_q[g] - 10'h001;
          end
          if (stopS2_q[g] && !stopSeen_q[g]) begin
            stopSeen_q[g] <= 1'b1;
            if (srCnt_q[g] != 10'h000) begin
              invalid_q[g] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // filter of the two converter results
  // ----------------------------------------
  function [15:0] filt;
    input [11:0] code;
    input        ovf;
    input [4:0]  ch;
    input        inval;
    input        lset;
    input [8:0]  lim;
    reg   [11:0] val;
    reg          below;
    reg          keep;
    reg          of;
    begin
      val = code;
      of  = ovf;
      if (cfg_q[`TDF_CFG_SLIDE]) begin
        val = code - slide_q;
      end
      below = 1'b0;
      if (lset) begin
        if (cfg_q[`TDF_CFG_GRAN]) begin
          below = (val[8:1] < lim[7:0]) && (val[11:9] == 3'b000);
        end else begin
          below = val[11:4] < lim[7:0];
        end
      end
      if (cfg_q[`TDF_CFG_SLIDE] && val > `TDF_SLIDE_MAX) begin
        of = 1'b1;
      end
      keep = !(lset && lim[`TDF_KILL_BIT]);
      keep = keep && (!below || cfg_q[`TDF_CFG_KEEPBELOW]);
      keep = keep && (!of || cfg_q[`TDF_CFG_KEEPOVF]);
      keep = keep && (!inval || cfg_q[`TDF_CFG_KEEPINV]);
      filt = {keep, inval, below, of, val};
    end
  endfunction

  wire [4:0]  chA = {1'b0, slot_q[3:0]};
  wire [4:0]  chB = {1'b1, slot_q[3:0]};
  wire [15:0] resA = filt(codeA_q, ovfA_q, chA, invalid_q[chA], limSet_q[chA], limMem[chA]);
  wire [15:0] resB = filt(codeB_q, ovfB_q, chB, invalid_q[chB], limSet_q[chB], limMem[chB]);
  reg  [15:0] pendB_q;
  reg         pendBV_q;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q        <= ST_IDLE;
      cyc_q          <= 16'h0000;
      slot_q         <= 5'h00;
      armed_q        <= {NCH{1'b0}};
      codeA_q        <= 12'h000;
      codeB_q        <= 12'h000;
      ovfA_q         <= 1'b0;
      ovfB_q         <= 1'b0;
      adcGroupSel    <= 2'b00;
      adcChanSel     <= 2'b00;
      timingDrive    <= 1'b0;
      dischargeDrive <= 1'b0;
      wordOut        <= 32'h0000_0000;
      wordValid      <= 1'b0;
      pendB_q        <= 16'h0000;
      pendBV_q       <= 1'b0;
      evCount_q      <= 16'h0000;
    end else begin
      wordValid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          dischargeDrive <= 1'b0;
          if ((timS2_q && !timPrev_q) || startReq_q) begin
            timingDrive <= 1'b1;
            cyc_q       <= 16'h0000;
            slot_q      <= 5'h00;
            state_q     <= ST_CONV;
          end
        end
        ST_CONV: begin
          timingDrive <= 1'b0;
          cyc_q       <= cyc_q + 16'h0001;
          adcGroupSel <= slot_q[3:2];
          adcChanSel  <= slot_q[1:0];
          if (cyc_q == SLICE_CYC[15:0] - 16'h0001) begin
            codeA_q <= adcCodeA;
            codeB_q <= adcCodeB;
            ovfA_q  <= adcOvfA;
            ovfB_q  <= adcOvfB;
          end
          if (cyc_q == SLICE_CYC[15:0]) begin
            cyc_q <= 16'h0000;
            if (resA[15]) begin
              wordOut   <= {5'h00, chA, 6'h00, resA};
              wordValid <= 1'b1;
            end
            pendB_q  <= resB;
            pendBV_q <= resB[15] && (NCH > CH_PER_ADC);
            slot_q   <= slot_q + 5'h01;
            if (slot_q == CH_PER_ADC[4:0] - 5'h01) begin
              state_q <= ST_DISCH;
            end
          end else if (pendBV_q) begin
            wordOut   <= {5'h00, {1'b1, slot_q[3:0] - 4'h1}, 6'h00, pendB_q};
            wordValid <= 1'b1;
            pendBV_q  <= 1'b0;
          end
        end
        ST_DISCH: begin
          if (pendBV_q) begin
            wordOut   <= {5'h00, {1'b1, 4'hF}, 6'h00, pendB_q};
            wordValid <= 1'b1;
            pendBV_q  <= 1'b0;
          end
          dischargeDrive <= 1'b1;
          cyc_q          <= cyc_q + 16'h0001;
          if (cyc_q == DISCH_CYC) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          dischargeDrive <= 1'b0;
          evCount_q      <= evCount_q + 16'h0001;
          state_q        <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_q       <= `TDF_CFG_RESET;
      slide_q     <= 12'h000;
      slideOffset <= 12'h000;
      startReq_q  <= 1'b0;
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
    end else begin
      startReq_q  <= 1'b0;
      slideOffset <= cfg_q[`TDF_CFG_SLIDE] ? slide_q : 12'h000;
      pready      <= rdPh;
      pslverr     <= 1'b0;
      if (rdPh) begin
        pslverr <= !(isLim || paddr == `TDF_OFF_CFG || paddr == `TDF_OFF_SLIDE ||
                     paddr == `TDF_OFF_STATUS || paddr == `TDF_OFF_COUNT ||
                     paddr == `TDF_OFF_OUTDATA || paddr == `TDF_OFF_START);
        if (isLim) begin
          prdata <= {23'h00_0000, limMem[limIdx]};
        end else if (paddr == `TDF_OFF_CFG) begin
          prdata <= {16'h0000, cfg_q};
        end else if (paddr == `TDF_OFF_SLIDE) begin
          prdata <= {20'h0_0000, slide_q};
        end else if (paddr == `TDF_OFF_STATUS) begin
          prdata <= {29'h0000_0000, state_q};
        end else if (paddr == `TDF_OFF_COUNT) begin
          prdata <= {16'h0000, evCount_q};
        end else if (paddr == `TDF_OFF_OUTDATA) begin
          prdata <= wordOut;
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
      if (wrEn && !pslverr) begin
        if (paddr == `TDF_OFF_CFG) begin
          cfg_q <= pwdata[15:0];
        end
        if (paddr == `TDF_OFF_SLIDE) begin
          slide_q <= pwdata[11:0];
        end
        if (paddr == `TDF_OFF_START) begin
          startReq_q <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [design/tdf_defs.vh]
// constants for the tdc conversion data filter
`ifndef TDF_DEFS_VH
`define TDF_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TDF_OFF_CFG       12'h000
`define TDF_OFF_SLIDE     12'h004
`define TDF_OFF_STATUS    12'h008
`define TDF_OFF_COUNT     12'h00C
`define TDF_OFF_OUTDATA   12'h010
`define TDF_OFF_START     12'h014
`define TDF_OFF_LIM_LO    12'h080
`define TDF_OFF_LIM_HI    12'h0BF
// ----------------------------------------
// configuration fields
// ----------------------------------------
`define TDF_CFG_KEEPBELOW 4
`define TDF_CFG_GRAN      8
`define TDF_CFG_STOPMODE  10
`define TDF_CFG_SLIDE     11
`define TDF_CFG_KEEPOVF   5
`define TDF_CFG_KEEPINV   6
`define TDF_CFG_RESET     16'h0000
// ----------------------------------------
// data word fields and code limits
// ----------------------------------------
`define TDF_DW_OVF        12
`define TDF_DW_BELOW      13
`define TDF_DW_INVALID    14
`define TDF_SLIDE_MAX     12'hF00
`define TDF_KILL_BIT      8
// ----------------------------------------
// timing
// ----------------------------------------
`define TDF_CLK_HZ        20000000
`define TDF_CONV32_NS     5700
`define TDF_CONV16_NS     2800
`define TDF_SELFRST_NS    700
`define TDF_DISCH_CYC     4
`endif

// [verif/tdf_adc_model.sv]
// converter model: level per channel plus sliding offset
`default_nettype none
module tdf_adc_model (
  input  wire logic [1:0]  adcGroupSel,
  input  wire logic [1:0]  adcChanSel,
  input  wire logic [11:0] slideOffset,
  output logic      [11:0] adcCodeA,
  output logic      [11:0] adcCodeB,
  output logic             adcOvfA,
  output logic             adcOvfB
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] lvl [32];
  logic        ovf [32];
  logic [3:0]  slot;
  assign slot = {adcGroupSel, adcChanSel};
  // offset added ahead of conversion, wraps like a real code
  assign adcCodeA = lvl[slot] + slideOffset;
  assign adcCodeB = lvl[{1'b1, slot}] + slideOffset;
  assign adcOvfA  = ovf[slot];
  assign adcOvfB  = ovf[{1'b1, slot}];
endmodule
`default_nettype wire

// [verif/tdf_filter_asserts.sv]
// port checker for the conversion data filter
`default_nettype none
module tdf_filter_asserts (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timingDrive,
  input wire logic        dischargeDrive,
  input wire logic [31:0] wordOut,
  input wire logic        wordValid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] cfg_q;
  logic        unmapped;
  logic        acc;
  assign unmapped = (paddr > 12'h014 && paddr < 12'h080) || paddr > 12'h0BF;
  assign acc = psel && penable && pready;
  // shadow of the configuration word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cfg_q <= 16'h0000;
    else if (acc && pwrite && paddr == 12'h000) cfg_q <= pwdata[15:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_ready_next;
    psel && !penable |=> pready && psel && penable;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("apb answer late");
  property p_err;
    acc |-> pslverr == unmapped;
  endproperty
  a_err: assert property (p_err) else $error("bad slave error");
  property p_start;
    acc && pwrite && paddr == 12'h014 |-> ##[1:2] timingDrive;
  endproperty
  a_start: assert property (p_start) else $error("no timing pulse");
  property p_pulse;
    timingDrive |=> !timingDrive [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("timing pulse repeats");
  property p_conv_len;
    timingDrive |-> ##[100:160] dischargeDrive;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length");
  property p_disch;
    $rose(dischargeDrive) |-> ##[1:8] !dischargeDrive;
  endproperty
  a_disch: assert property (p_disch) else $error("discharge too long");
  property p_below;
    wordValid && wordOut[13] |-> cfg_q[4];
  endproperty
  a_below: assert property (p_below) else $error("below word kept");
  property p_ovf;
    wordValid && wordOut[12] |-> cfg_q[5];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow word kept");
  property p_slide;
    wordValid && cfg_q[11] && !wordOut[12] |-> wordOut[11:0] <= 12'hF00;
  endproperty
  a_slide: assert property (p_slide) else $error("slide code too high");
endmodule
bind tdf_data_filter tdf_filter_asserts i_tdf_filter_asserts (.clk, .rstn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .timingDrive, .dischargeDrive, .wordOut,
  .wordValid);
`default_nettype wire

// [verif/tdc_conversion_data_filter_tb.sv]
// self-checking bench for the conversion data filter
`default_nettype none
`include "tdf_defs.vh"
module tdc_conversion_data_filter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, sharedTimingInput = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, chanStopIn = '1, chanSaturated = '0, rd, got [32];
  wire  [31:0] prdata, wordOut;
  wire         pready, pslverr, adcOvfA, adcOvfB, timingDrive, dischargeDrive, wordValid;
  wire  [11:0] adcCodeA, adcCodeB, slideOffset;
  wire  [1:0]  adcGroupSel, adcChanSel;
  logic [8:0]  lim [32];
  logic        hit [32];
  logic [15:0] cfgs [10] = '{16'h0000, 16'h0010, 16'h0100, 16'h0110, 16'h0020, 16'h0030,
                             16'h0800, 16'h0820, 16'h0400, 16'h0440};
  int          bad_count = 0, n_checks = 0;
  tdf_data_filter i_tdf_data_filter (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .chanStopIn, .sharedTimingInput, .adcCodeA, .adcCodeB,
    .adcOvfA, .adcOvfB, .chanSaturated, .adcGroupSel, .adcChanSel, .slideOffset,
    .timingDrive, .dischargeDrive, .wordOut, .wordValid);
  tdf_adc_model i_tdf_adc_model (.adcGroupSel, .adcChanSel, .slideOffset, .adcCodeA,
    .adcCodeB, .adcOvfA, .adcOvfB);
  always #25 clk = ~clk;
  always @(posedge clk) if (wordValid === 1'b1) begin
    hit[wordOut[26:22]] <= 1'b1;
    got[wordOut[26:22]] <= wordOut;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic err = 0);
    int k;
    @(posedge clk);
    psel <= 1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    k = 0;
    do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    check("pready", pready, 1);
    check("pslverr", pslverr, err);
    psel <= 0; penable <= 0;
  endtask
  task automatic setc(int n, logic [11:0] c, logic o, logic [8:0] l);
    i_tdf_adc_model.lvl[n] = c;
    i_tdf_adc_model.ovf[n] = o;
    lim[n] = l;
    if (l != 0) apb(1, 12'h080 + 12'(2 * n), {23'h0, l});
  endtask
  // expected {stored, word} from level, overflow, limit and config
  function automatic logic [32:0] expw(int n, logic [15:0] cfg);
    logic [11:0] c;
    logic        b, o, v;
    c = i_tdf_adc_model.lvl[n];
    o = i_tdf_adc_model.ovf[n] | (cfg[11] && c > 12'd3840);
    v = cfg[10] && n == 7;
    b = lim[n] != 0 && (cfg[8] ? (c[8:1] < lim[n][7:0] && c[11:9] == 0)
                               : c < {lim[n][7:0], 4'h0});
    return {!lim[n][8] && (!b || cfg[4]) && (!o || cfg[5]) && (!v || cfg[6]), 5'h0, n[4:0],
            7'h0, v, b, o, c};
  endfunction
  task automatic conv(logic [15:0] cfg, logic viaPin);
    int          k;
    logic [32:0] e;
    apb(1, `TDF_OFF_CFG, cfg);
    apb(0, `TDF_OFF_CFG, 0);
    check("cfg", rd, cfg);
    hit = '{default: 1'b0};
    // saturate channel 7 just ahead of the start in common-stop mode
    chanSaturated[7] <= cfg[10];
    @(posedge clk);
    chanSaturated[7] <= 1'b0;
    if (viaPin) begin
      @(posedge clk);
      sharedTimingInput <= 1;
      repeat (4) @(posedge clk);
      sharedTimingInput <= 0;
    end else apb(1, `TDF_OFF_START, 1);
    k = 0;
    while (dischargeDrive !== 1'b1 && k < 400) begin @(posedge clk); k++; end
    while (dischargeDrive !== 1'b0 && k < 400) begin @(posedge clk); k++; end
    for (int n = 0; n < 32; n++) begin
      e = expw(n, cfg);
      check("stored", hit[n], e[32]);
      if (e[32]) check("word", got[n] & 32'hFFFF_7FFF, e[31:0]);
    end
  endtask
  initial begin
    for (int n = 0; n < 32; n++) setc(n, 12'h800, 0, 9'h000);
    repeat (20) @(posedge clk);
    rstn <= 1;
    apb(0, `TDF_OFF_CFG, 0);
    check("cfg reset", rd, {16'h0000, `TDF_CFG_RESET});
    apb(0, 12'h040, 0, 1);
    apb(1, 12'h0C0, 32'h0000_FFFF, 1);
    setc(0, 12'h0FF, 0, 9'h010);
    setc(1, 12'h100, 0, 9'h010);
    setc(2, 12'h01F, 0, 9'h010);
    setc(3, 12'h020, 0, 9'h010);
    setc(4, 12'h900, 1, 9'h000);
    setc(5, 12'h800, 0, 9'h100);
    setc(6, 12'hF01, 0, 9'h000);
    setc(20, 12'h0FF, 0, 9'h010);
    apb(1, `TDF_OFF_SLIDE, 32'h0000_0123);
    for (int i = 0; i < 10; i++) conv(cfgs[i], i[0]);
    @(posedge clk);
    rstn <= 0;
    repeat (3) @(posedge clk);
    rstn <= 1;
    conv(16'h0000, 1'b0);
    apb(0, 12'h080, 0);
    check("limit kept", rd, 32'h0000_0010);
    apb(0, `TDF_OFF_COUNT, 0);
    check("count", rd, 32'h0000_0001);
    apb(0, `TDF_OFF_STATUS, 0);
    check("status", rd, 32'h0000_0000);
    apb(0, `TDF_OFF_OUTDATA, 0);
    check("outdata", rd, 32'h07C0_8800);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
